// ===== cld_column_driver.sv
// column driver datapath: nibble capture, chain enable, line latch
`timescale 1ns/100ps
// Operation
// - each nibble on the data pins is captured on a shift clock fall.
// - the whole shifted line moves to the output latch on latch fall.
// - column outputs change only at latch falls or frame polarity changes and hold in between.
// - data arrives as a four-bit nibble, all four lines driven.
// - the chain enable input is active high and enables acceptance.
// - the chain enable output goes high to enable the next driver.
// - the chain enable state advances on chain enable clock falls.
// - a latch pulse returns the chain enable output to inactive.
// - nibbles pass a 16 x 4 shift register into a 64-bit latch.
// - each column level is chosen by its latched bit and the frame.
module cld_column_driver (
   input wire logic clk, // system clock, 40 MHz
   input wire logic rst, // synchronous reset, high
   input wire logic shift_clk, // pixel shift clock, data on fall
   input wire logic [3:0] pixel_nibble_in, // display data nibble
   input wire logic line_latch_pulse, // line latch, acts on fall
   input wire logic frame_ac_drive, // frame polarity signal
   input wire logic chain_enable_in, // cascade enable, high
   input wire logic chain_enable_clock, // cascade clock, acts on fall
   output logic chain_enable_out, // enable to next driver, high
   output logic [63:0] column_outputs, // column drive polarity
   output logic overrun // nibble dropped, fifo full
);
   // ------------------------------------------------------------
   // link domain: shift clock falling edge
   // ------------------------------------------------------------
   logic [1:0] lrst_q;
   logic [3:0] lnib_q;
   logic ltog_q;

   // reset reaches the link domain only through shift clock edges
   always_ff @(negedge shift_clk) begin
      lrst_q <= {lrst_q[0], rst};
   end

   always_ff @(negedge shift_clk) begin
      lnib_q <= pixel_nibble_in;
   end

   always_ff @(negedge shift_clk) begin
      if (lrst_q[1]) begin
         ltog_q <= 1'b0;
      end else begin
         ltog_q <= ~ltog_q;
      end
   end

   // ------------------------------------------------------------
   // crossings into the system clock domain
   // ------------------------------------------------------------
   logic tog_s1_q;
   logic tog_s2_q;
   logic tog_s3_q;
   cld_pkg::cld_pins_t pin_s1_q;
   cld_pkg::cld_pins_t pin_s2_q;
   cld_pkg::cld_pins_t pin_s3_q;
   logic nib_ev;
   logic lp_fall;
   logic ecl_fall;
   logic fr_lvl;

   always_ff @(posedge clk) begin
      if (rst) begin
         tog_s1_q <= 1'b0;
         tog_s2_q <= 1'b0;
         tog_s3_q <= 1'b0;
      end else begin
         tog_s1_q <= ltog_q;
         tog_s2_q <= tog_s1_q;
         tog_s3_q <= tog_s2_q;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_s1_q <= cld_pkg::PINS_RST;
         pin_s2_q <= cld_pkg::PINS_RST;
         pin_s3_q <= cld_pkg::PINS_RST;
      end else begin
         pin_s1_q <= {line_latch_pulse, frame_ac_drive,
                      chain_enable_in, chain_enable_clock};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // lnib_q is stable for a whole shift period, well past the sync delay
   assign nib_ev = tog_s2_q ^ tog_s3_q;
   assign lp_fall = pin_s3_q.latch & ~pin_s2_q.latch;
   assign ecl_fall = pin_s3_q.chain_clk & ~pin_s2_q.chain_clk;
   assign fr_lvl = pin_s2_q.frame;

   // ------------------------------------------------------------
   // daisy chain enable
   // ------------------------------------------------------------
   cld_pkg::cld_chain_st_t state_q;
   logic arm_q;
   logic [3:0] nib_cnt_q;
   logic push;
   logic fifo_in_ready;

   assign push = nib_ev & (state_q == cld_pkg::ST_FILL) & fifo_in_ready;

   // enable seen while the latch is high waits for its fall, so a
   // latch pulse wired to the chain input starts the new line
   always_ff @(posedge clk) begin
      if (rst) begin
         arm_q <= 1'b0;
      end else if (ecl_fall && pin_s2_q.chain_in) begin
         arm_q <= 1'b1;
      end else if (state_q == cld_pkg::ST_FILL) begin
         arm_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= cld_pkg::ST_IDLE;
      end else if (lp_fall) begin
         state_q <= cld_pkg::ST_IDLE;
      end else begin
         unique case (state_q)
            cld_pkg::ST_IDLE: begin
               if (arm_q && !pin_s2_q.latch) begin
                  state_q <= cld_pkg::ST_FILL;
               end
            end
            cld_pkg::ST_FILL: begin
               if (push && nib_cnt_q == cld_pkg::LAST_NIB) begin
                  state_q <= cld_pkg::ST_FULL;
               end
            end
            cld_pkg::ST_FULL: begin
               state_q <= cld_pkg::ST_FULL;
            end
            default: begin
               state_q <= cld_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst || lp_fall) begin
         nib_cnt_q <= cld_pkg::NIB_CNT_RST;
      end else if (push) begin
         nib_cnt_q <= nib_cnt_q + 1'b1;
      end
   end

   assign chain_enable_out = (state_q == cld_pkg::ST_FULL);

   // a shift edge met by a full fifo cannot be held off at the pins
   always_ff @(posedge clk) begin
      if (rst) begin
         overrun <= 1'b0;
      end else if (nib_ev && state_q == cld_pkg::ST_FILL
                   && !fifo_in_ready) begin
         overrun <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // nibble buffer
   // ------------------------------------------------------------
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [3:0] fifo_out_data;
   logic [4:0] sh_cnt_q;
   logic pop;

   cld_fifo #(
      .WIDTH(cld_pkg::NIB_W),
      .DEPTH(cld_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(nib_ev & (state_q == cld_pkg::ST_FILL)),
      .in_ready(fifo_in_ready),
      .in_data(lnib_q),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // drain stalls once a line is complete until the latch takes it
   assign fifo_out_ready = (sh_cnt_q != cld_pkg::SH_FULL) & ~lp_fall;
   assign pop = fifo_out_valid & fifo_out_ready;

   // ------------------------------------------------------------
   // shift register and line latch
   // ------------------------------------------------------------
   logic [3:0] shreg_q [cld_pkg::STAGES];
   logic [63:0] line_w;
   logic [63:0] latch_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < cld_pkg::STAGES; i++) begin
            shreg_q[i] <= 4'h0;
         end
      end else if (pop) begin
         shreg_q[0] <= fifo_out_data;
         for (int i = 1; i < cld_pkg::STAGES; i++) begin
            shreg_q[i] <= shreg_q[i-1];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst || lp_fall) begin
         sh_cnt_q <= cld_pkg::SH_CNT_RST;
      end else if (pop) begin
         sh_cnt_q <= sh_cnt_q + 1'b1;
      end
   end

   // first nibble of the line lands on columns 0 to 3
   generate
      for (genvar k = 0; k < cld_pkg::STAGES; k++) begin : g_map
         assign line_w[4*k +: 4] = shreg_q[cld_pkg::STAGES-1-k];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         latch_q <= cld_pkg::COL_RST;
      end else if (lp_fall) begin
         latch_q <= line_w;
      end
   end

   // ------------------------------------------------------------
   // column drive
   // ------------------------------------------------------------
   // moves only with the latch or with a frame polarity change
   always_ff @(posedge clk) begin
      if (rst) begin
         column_outputs <= cld_pkg::COL_RST;
      end else begin
         column_outputs <= latch_q ^ {64{fr_lvl}};
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_arm_idle;
      ecl_fall && pin_s2_q.chain_in && state_q == cld_pkg::ST_IDLE;
   endsequence

   sequence s_latch_low2;
      (!pin_s2_q.latch && !lp_fall) [*2];
   endsequence

   property p_eo_clear;
      lp_fall |=> !chain_enable_out;
   endproperty
   a_eo_clear: assert property (p_eo_clear)
      else $error("chain enable out not cleared by latch");

   property p_ignore_idle;
      (nib_ev && state_q == cld_pkg::ST_IDLE && !lp_fall)
         |=> nib_cnt_q == $past(nib_cnt_q);
   endproperty
   a_ignore_idle: assert property (p_ignore_idle)
      else $error("nibble accepted while chain disabled");

   property p_col_hold;
      $changed(column_outputs)
         |-> $past(lp_fall, 2) || ($past(fr_lvl) != $past(fr_lvl, 2));
   endproperty
   a_col_hold: assert property (p_col_hold)
      else $error("columns moved without latch or frame change");

   property p_latch_xfer;
      lp_fall |=> latch_q == $past(line_w) ##1
         column_outputs == ($past(latch_q) ^ {64{$past(fr_lvl)}});
   endproperty
   a_latch_xfer: assert property (p_latch_xfer)
      else $error("line not transferred to columns");

   property p_capture;
      (push && nib_cnt_q != cld_pkg::LAST_NIB && !lp_fall)
         |=> nib_cnt_q == $past(nib_cnt_q) + 4'h1;
   endproperty
   a_capture: assert property (p_capture)
      else $error("accepted nibble not counted");

   property p_enable;
      s_arm_idle ##1 s_latch_low2 |-> state_q == cld_pkg::ST_FILL;
   endproperty
   a_enable: assert property (p_enable)
      else $error("chain enable input did not enable driver");

   property p_eo_after16;
      (push && nib_cnt_q == cld_pkg::LAST_NIB && !lp_fall)
         |=> chain_enable_out;
   endproperty
   a_eo_after16: assert property (p_eo_after16)
      else $error("chain enable out not raised after full line");

   property p_eo_source;
      $rose(chain_enable_out) |-> $past(state_q) == cld_pkg::ST_FILL
         && $past(nib_cnt_q) == cld_pkg::LAST_NIB;
   endproperty
   a_eo_source: assert property (p_eo_source)
      else $error("chain enable out raised early");

   property p_shift_stall;
      sh_cnt_q == cld_pkg::SH_FULL && !lp_fall
         |=> sh_cnt_q == cld_pkg::SH_FULL;
   endproperty
   a_shift_stall: assert property (p_shift_stall)
      else $error("shift register overfilled");

   property p_arm_take;
      ecl_fall && pin_s2_q.chain_in |=> arm_q;
   endproperty
   a_arm_take: assert property (p_arm_take)
      else $error("chain enable clock fall did not arm driver");

   property p_arm_refuse;
      ecl_fall && !pin_s2_q.chain_in && !arm_q |=> !arm_q;
   endproperty
   a_arm_refuse: assert property (p_arm_refuse)
      else $error("low chain enable input armed driver");

   property p_col_drive;
      column_outputs == ($past(latch_q) ^ {64{$past(fr_lvl)}});
   endproperty
   a_col_drive: assert property (p_col_drive)
      else $error("column level does not follow latch and frame");
endmodule

// ===== cld_pkg.sv
// shared constants and types for the lcd column driver datapath
package cld_pkg;
   // ------------------------------------------------------------
   // datapath geometry
   // ------------------------------------------------------------
   localparam int NIB_W = 4;
   localparam int STAGES = 16;
   localparam int COLS = 64;
   localparam int FIFO_DEPTH = 32;
   // ------------------------------------------------------------
   // counter values and reset values
   // ------------------------------------------------------------
   localparam logic [3:0] LAST_NIB = 4'hf;
   localparam logic [3:0] NIB_CNT_RST = 4'h0;
   localparam logic [4:0] SH_FULL = 5'h10;
   localparam logic [4:0] SH_CNT_RST = 5'h00;
   localparam logic [63:0] COL_RST = 64'h0;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FILL = 2'b01,
      ST_FULL = 2'b11
   } cld_chain_st_t;
   typedef struct packed {
      logic latch;
      logic frame;
      logic chain_in;
      logic chain_clk;
   } cld_pins_t;
   localparam cld_pins_t PINS_RST = 4'h0;
endpackage

// ===== cld_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module cld_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 32
) (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset, high
   input wire logic in_valid, // write request
   output logic in_ready, // space available
   input wire logic [WIDTH-1:0] in_data, // write word
   output logic out_valid, // word available
   input wire logic out_ready, // reader takes word
   output logic [WIDTH-1:0] out_data // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic wr;
   logic rd;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rp_q];
   assign wr = in_valid & in_ready;
   assign rd = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (wr) begin
         mem_q[wp_q] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (wr) begin
            wp_q <= wp_q + 1'b1;
         end
         if (rd) begin
            rp_q <= rp_q + 1'b1;
         end
         if (wr && !rd) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (rd && !wr) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// ===== cld_ctrl_model.sv
// controller model driving the column driver's data and timing pins
`timescale 1ns/100ps
module cld_ctrl_model (
   input wire logic clk, // system clock
   output logic shift_clk, // link clock, still between transfers
   output logic [3:0] pixel_nibble_in, // display nibble
   output logic line_latch_pulse, // line latch, acts on fall
   output logic frame_ac_drive, // frame polarity
   output logic chain_enable_in, // cascade enable to the driver
   output logic chain_enable_clock // cascade clock, acts on fall
);
   initial begin
      shift_clk = 1'b1;
      pixel_nibble_in = 4'h0;
      line_latch_pulse = 1'b0;
      frame_ac_drive = 1'b0;
      chain_enable_in = 1'b0;
      chain_enable_clock = 1'b0;
   end
   // ------------------------------------------------------------
   // link transfer: one nibble per 125 ns period
   // ------------------------------------------------------------
   task automatic shift_nib(input logic [3:0] n);
      pixel_nibble_in = n;
      #61.5 shift_clk = 1'b0;
      // hold time over, so the old value must not linger
      #30 pixel_nibble_in = ~n;
      #33.5 shift_clk = 1'b1;
   endtask
   // ------------------------------------------------------------
   // chain and latch timing
   // ------------------------------------------------------------
   task automatic chain_pulse(input logic en);
      @(negedge clk) chain_enable_in <= en;
      chain_enable_clock <= 1'b1;
      repeat (3) @(negedge clk);
      chain_enable_clock <= 1'b0;
      repeat (3) @(negedge clk);
      chain_enable_in <= 1'b0;
   endtask
   // latch doubles as enable for the next line when as_en is set
   task automatic latch(input logic as_en);
      @(negedge clk) line_latch_pulse <= 1'b1;
      chain_enable_in <= as_en;
      repeat (2) @(negedge clk);
      chain_enable_clock <= as_en;
      repeat (3) @(negedge clk);
      chain_enable_clock <= 1'b0;
      repeat (3) @(negedge clk);
      line_latch_pulse <= 1'b0;
      chain_enable_in <= 1'b0;
   endtask
   task automatic set_frame(input logic f);
      @(negedge clk) frame_ac_drive <= f;
   endtask
endmodule

// ===== cld_column_driver_bench.sv
// self-checking bench for the column driver datapath
`timescale 1ns/100ps
module cld_column_driver_bench;
   logic clk, rst, shift_clk, line_latch_pulse, frame_ac_drive;
   logic chain_enable_in, chain_enable_clock, chain_enable_out, overrun;
   logic [3:0] pixel_nibble_in, nib;
   logic [63:0] column_outputs, exp_cols, exp_prev;
   logic [31:0] rng;
   int errors, total_checks;
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   cld_column_driver cld_column_driver_i (
      .clk(clk), .rst(rst), .shift_clk(shift_clk),
      .pixel_nibble_in(pixel_nibble_in),
      .line_latch_pulse(line_latch_pulse),
      .frame_ac_drive(frame_ac_drive),
      .chain_enable_in(chain_enable_in),
      .chain_enable_clock(chain_enable_clock),
      .chain_enable_out(chain_enable_out),
      .column_outputs(column_outputs), .overrun(overrun)
   );
   cld_ctrl_model cld_ctrl_model_i (
      .clk(clk), .shift_clk(shift_clk), .pixel_nibble_in(pixel_nibble_in),
      .line_latch_pulse(line_latch_pulse), .frame_ac_drive(frame_ac_drive),
      .chain_enable_in(chain_enable_in),
      .chain_enable_clock(chain_enable_clock)
   );
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   function automatic logic [63:0] drive(input logic [63:0] d);
      return d ^ {64{frame_ac_drive}};
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wait_eo;
      int n;
      n = 0;
      while (chain_enable_out !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (chain_enable_out !== 1'b1) begin
         errors++;
         end_of_test();
      end
   endtask
   task automatic send_rand(input int cnt);
      repeat (cnt) begin
         rng = xs(rng);
         cld_ctrl_model_i.shift_nib(rng[3:0]);
      end
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      errors = 0;
      total_checks = 0;
      rng = 32'h45;
      rst = 1'b1;
      exp_prev = 64'h0;
      fork
         begin
            repeat (10) @(negedge clk);
            rst = 1'b0;
         end
         begin
            @(negedge clk);
            send_rand(2);
         end
      join
      check(column_outputs, 64'h0);
      check({63'h0, chain_enable_out}, 64'h0);
      repeat (3) @(negedge clk);
      // low enable: the whole line must be ignored
      cld_ctrl_model_i.chain_pulse(1'b0);
      send_rand(16);
      repeat (60) @(negedge clk);
      check({63'h0, chain_enable_out}, 64'h0);
      cld_ctrl_model_i.chain_pulse(1'b1);
      repeat (10) @(negedge clk);
      for (int line = 0; line < 4; line++) begin
         for (int i = 0; i < 16; i++) begin
            rng = xs(rng);
            nib = (line == 0) ? i[3:0] : rng[3:0];
            exp_cols[4*i +: 4] = nib;
            if (i == 15) begin
               repeat (20) @(negedge clk);
               check({63'h0, chain_enable_out}, 64'h0);
            end
            cld_ctrl_model_i.shift_nib(nib);
         end
         wait_eo();
         check({63'h0, chain_enable_out}, 64'h1);
         // full driver must ignore these
         send_rand(2);
         repeat (60) @(negedge clk);
         check(column_outputs, drive(exp_prev));
         cld_ctrl_model_i.latch(1'b1);
         repeat (10) @(negedge clk);
         check(column_outputs, drive(exp_cols));
         check({63'h0, chain_enable_out}, 64'h0);
         exp_prev = exp_cols;
         cld_ctrl_model_i.set_frame(~frame_ac_drive);
         repeat (8) @(negedge clk);
         check(column_outputs, drive(exp_prev));
      end
      check({63'h0, overrun}, 64'h0);
      end_of_test();
   end
endmodule
